//--- rtl/cpr_regs.sv
// Control port register group with eeprom port, power and RAM load
// ****************************************
// ****************************************
`default_nettype none
module cpr_regs
  import cpr_pkg::*;
#(
  parameter int RAM_AW = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic eeprom_clk_out,
  output logic eeprom_dout_out,
  output logic eeprom_port_en_out,
  input wire logic peripheral_data_pin0_in,
  input wire logic hwcfg_load_in,
  input wire logic [2:0] hwcfg_pol_in,
  input wire logic modem_irq_pin_in,
  input wire logic synth_irq_pin_in,
  input wire logic optical_drive_irq_pin_in,
  output logic modem_irq_out,
  output logic synth_irq_out,
  output logic optical_drive_irq_out,
  output logic [1:0] loopback_mux_select_out,
  output logic [6:0] section_off_out,
  output logic global_power_down_out,
  output logic calibrate_out,
  input wire logic processor_off_if_access_in,
  output logic [3:0] indirect_index_bits_out,
  output logic indirect_wr_out,
  output logic indirect_rd_out,
  output logic [7:0] indirect_data_bits_out,
  input wire logic [7:0] indirect_rdata_in,
  output logic pnp_key_off_out,
  output logic vendor_key_off_out,
  output logic jump_rom_out,
  output logic hwcfg_update_out,
  output logic ram_wr_valid_out,
  input wire logic ram_wr_ready_in,
  output logic [RAM_AW-1:0] ram_wr_addr_out,
  output logic [7:0] ram_wr_data_out,
  output logic ram_busy_out
);
  import cpr_pkg::*;
  // ****************************************
  // State
  // ****************************************
  localparam int BW = RAM_AW + 8;
  typedef struct packed {
    logic [7:0] ee;
    logic [7:0] pd;
    logic [3:0] idx;
    logic [7:0] rdata;
    logic ee_clk;
    logic ee_dout;
    logic ee_en;
    logic [2:0] irq;
    logic processor_off_sleep;
    logic [15:0] cal_cnt;
    logic cal;
    logic iwr;
    logic ird;
    logic [7:0] idata;
    logic pnp_off;
    logic vend_off;
    logic jump;
    logic upd;
    cpr_ram_e ram_st;
    logic [RAM_AW-1:0] ram_addr;
    logic [6:0] soff;
    logic busy;
  } cpr_regs_s;
  cpr_regs_s st_ff;
  cpr_regs_s nxt_st;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [BW-1:0] buf_out_data;
  logic buf_out_valid;
  logic wr_ee;
  logic wr_pd;
  logic gpd;
  logic [2:0] irq_pin;
  logic wr_idx;
  logic wr_idat;
  logic rd_idat;
  logic wr_cmd;
  logic wr_end;
  logic idx_ok;
  logic [2:0] irq_pol;
  logic [2:0] irq_norm;
  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (RAM_AW < 9 || RAM_AW > 16) $error("cpr_regs: RAM_AW must be 9 to 16");
    if (CPR_CAL_CYCLES < 1 || CPR_CAL_CYCLES > 65535) $error("cpr_regs: calibration count must fit 16 bits");
  end
  // ****************************************
  // Decodes
  // ****************************************
  assign gpd = st_ff.pd[CPR_PD_GLOBAL];
  assign wr_ee = wr_in && addr_in == CPR_OFS_EEPROM && !gpd;
  assign wr_pd = wr_in && addr_in == CPR_OFS_PDOWN;
  assign wr_idx = wr_in && !gpd && addr_in == CPR_OFS_INDEX;
  assign wr_idat = wr_in && !gpd && addr_in == CPR_OFS_IDATA;
  assign rd_idat = rd_in && !gpd && addr_in == CPR_OFS_IDATA;
  assign wr_cmd = wr_in && !gpd && addr_in == CPR_OFS_RAMCMD;
  assign wr_end = wr_in && !gpd && addr_in == CPR_OFS_RAMEND && wdata_in == CPR_ZERO;
  assign idx_ok = (st_ff.idx <= CPR_INDEX_MAX);
  // ****************************************
  // Interrupt polarity
  // ****************************************
  assign irq_pin = {optical_drive_irq_pin_in, synth_irq_pin_in, modem_irq_pin_in};
  assign irq_pol = {st_ff.ee[CPR_EE_OPT_POL], st_ff.ee[CPR_EE_SYNTH_POL], st_ff.ee[CPR_EE_MODEM_POL]};
  for (genvar i = 0; i < 3; i++) begin : g_irq
    assign irq_norm[i] = ~(irq_pin[i] ^ irq_pol[i]);
  end
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.iwr = 1'b0;
    nxt_st.ird = 1'b0;
    nxt_st.jump = 1'b0;
    nxt_st.upd = 1'b0;
    buf_in_valid = 1'b0;
    // ****************************************
    // Eeprom port register
    // ****************************************
    if (wr_ee) begin
      nxt_st.ee = wdata_in;
    end
    if (hwcfg_load_in) begin
      nxt_st.ee[CPR_EE_OPT_POL] = hwcfg_pol_in[2];
      nxt_st.ee[CPR_EE_SYNTH_POL] = hwcfg_pol_in[1];
      nxt_st.ee[CPR_EE_MODEM_POL] = hwcfg_pol_in[0];
    end
    nxt_st.ee_en = nxt_st.ee[CPR_EE_EN] && !gpd;
    nxt_st.ee_clk = nxt_st.ee[CPR_EE_CLK] && nxt_st.ee_en;
    nxt_st.ee_dout = nxt_st.ee[CPR_EE_DOUT] && nxt_st.ee_en;
    // ****************************************
    // Interrupt pins normalised to active high
    // ****************************************
    nxt_st.irq = irq_norm;
    // ****************************************
    // Power down and calibration
    // ****************************************
    if (wr_pd) begin
      nxt_st.pd = wdata_in;
      if (!wdata_in[CPR_PD_GLOBAL]) begin
        if (gpd) begin
          nxt_st.cal = 1'b1;
          nxt_st.cal_cnt = 16'(CPR_CAL_CYCLES);
          nxt_st.processor_off_sleep = 1'b1;
        end else if (st_ff.processor_off_sleep) begin
          nxt_st.processor_off_sleep = 1'b0;
        end
      end
    end
    if (st_ff.cal && !gpd) begin
      nxt_st.cal_cnt = st_ff.cal_cnt - 16'h0001;
      if (st_ff.cal_cnt == 16'h0001) begin
        nxt_st.cal = 1'b0;
      end
    end
    if (processor_off_if_access_in && !gpd) begin
      nxt_st.processor_off_sleep = 1'b0;
    end
    // ****************************************
    // Indirect access
    // ****************************************
    if (wr_idx) begin
      nxt_st.idx = wdata_in[3:0];
    end
    if (wr_idat && idx_ok) begin
      nxt_st.iwr = 1'b1;
      nxt_st.idata = wdata_in;
    end
    if (rd_idat && idx_ok) begin
      nxt_st.ird = 1'b1;
    end
    // ****************************************
    // RAM access command port
    // ****************************************
    if (wr_end) begin
      nxt_st.ram_st = CPR_RAM_CMD;
    end
    if (wr_cmd) begin
      case (st_ff.ram_st)
        CPR_RAM_CMD: begin
          case (wdata_in)
            CPR_CMD_NO_PNP_KEY: begin
              nxt_st.pnp_off = 1'b1;
            end
            CPR_CMD_NO_VEND_KEY: begin
              nxt_st.vend_off = 1'b1;
            end
            CPR_CMD_JUMP_ROM: begin
              nxt_st.jump = 1'b1;
            end
            CPR_CMD_UPD_HWCFG: begin
              nxt_st.upd = 1'b1;
            end
            CPR_CMD_DOWNLOAD: begin
              nxt_st.ram_st = CPR_RAM_ADDR_HI;
            end
            default: begin
              nxt_st.ram_st = CPR_RAM_CMD;
            end
          endcase
        end
        CPR_RAM_ADDR_HI: begin
          nxt_st.ram_addr[RAM_AW-1:8] = wdata_in[RAM_AW-9:0];
          nxt_st.ram_st = CPR_RAM_ADDR_LO;
        end
        CPR_RAM_ADDR_LO: begin
          nxt_st.ram_addr[7:0] = wdata_in;
          nxt_st.ram_st = CPR_RAM_DATA;
        end
        CPR_RAM_DATA: begin
          if (buf_in_ready) begin
            buf_in_valid = 1'b1;
            nxt_st.ram_addr = st_ff.ram_addr + RAM_AW'(1);
          end
        end
        default: nxt_st.ram_st = CPR_RAM_CMD;
      endcase
    end
    // ****************************************
    // Read data
    // ****************************************
    nxt_st.rdata = CPR_ZERO;
    if (rd_in) begin
      case (addr_in)
        CPR_OFS_EEPROM: begin
          nxt_st.rdata = st_ff.ee;
          nxt_st.rdata[CPR_EE_EN] = peripheral_data_pin0_in && st_ff.ee[CPR_EE_EN]
            && st_ff.ee[CPR_EE_DOUT];
        end
        CPR_OFS_PDOWN: begin
          nxt_st.rdata = st_ff.pd;
        end
        CPR_OFS_INDEX: begin
          nxt_st.rdata = {4'h0, st_ff.idx};
        end
        CPR_OFS_IDATA: begin
          nxt_st.rdata = indirect_rdata_in;
        end
        default: begin
          nxt_st.rdata = CPR_ZERO;
        end
      endcase
      if (gpd && addr_in != CPR_OFS_PDOWN) begin
        nxt_st.rdata = CPR_ZERO;
      end
    end
    // ****************************************
    // Registered status outputs
    // ****************************************
    nxt_st.soff = {nxt_st.pd[6:2], nxt_st.pd[CPR_PD_PROCESSOR_OFF] | nxt_st.processor_off_sleep, nxt_st.pd[0]};
    nxt_st.busy = (nxt_st.ram_st != CPR_RAM_CMD);
  end
  // ****************************************
  // RAM write buffer
  // ****************************************
  cpr_buf2 #(
    .WIDTH(BW)
  ) u_buf (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .in_data_in({st_ff.ram_addr, wdata_in}),
    .out_valid_out(buf_out_valid),
    .out_ready_in(ram_wr_ready_in),
    .out_data_out(buf_out_data)
  );
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.ee <= CPR_EE_RESET;
      st_ff.pd <= CPR_PD_RESET;
      st_ff.ram_st <= CPR_RAM_CMD;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_out = st_ff.rdata;
  assign eeprom_clk_out = st_ff.ee_clk;
  assign eeprom_dout_out = st_ff.ee_dout;
  assign eeprom_port_en_out = st_ff.ee_en;
  assign modem_irq_out = st_ff.irq[0];
  assign synth_irq_out = st_ff.irq[1];
  assign optical_drive_irq_out = st_ff.irq[2];
  assign loopback_mux_select_out = st_ff.ee[CPR_EE_MUX_LO+1:CPR_EE_MUX_LO];
  assign section_off_out = st_ff.soff;
  assign global_power_down_out = gpd;
  assign calibrate_out = st_ff.cal;
  assign indirect_index_bits_out = st_ff.idx;
  assign indirect_wr_out = st_ff.iwr;
  assign indirect_rd_out = st_ff.ird;
  assign indirect_data_bits_out = st_ff.idata;
  assign pnp_key_off_out = st_ff.pnp_off;
  assign vendor_key_off_out = st_ff.vend_off;
  assign jump_rom_out = st_ff.jump;
  assign hwcfg_update_out = st_ff.upd;
  assign ram_wr_valid_out = buf_out_valid;
  assign ram_wr_addr_out = buf_out_data[BW-1:8];
  assign ram_wr_data_out = buf_out_data[7:0];
  assign ram_busy_out = st_ff.busy;
endmodule
`default_nettype wire

//--- rtl/cpr_pkg.sv
// Constants for the control port register group
`default_nettype none
package cpr_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] CPR_OFS_EEPROM = 3'h1;
  localparam logic [2:0] CPR_OFS_PDOWN = 3'h2;
  localparam logic [2:0] CPR_OFS_INDEX = 3'h3;
  localparam logic [2:0] CPR_OFS_IDATA = 3'h4;
  localparam logic [2:0] CPR_OFS_RAMCMD = 3'h5;
  localparam logic [2:0] CPR_OFS_RAMEND = 3'h6;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CPR_EE_CLK = 0;
  localparam int CPR_EE_DOUT = 1;
  localparam int CPR_EE_EN = 2;
  localparam int CPR_EE_MODEM_POL = 3;
  localparam int CPR_EE_MUX_LO = 4;
  localparam int CPR_EE_SYNTH_POL = 6;
  localparam int CPR_EE_OPT_POL = 7;
  localparam int CPR_PD_GLOBAL = 7;
  localparam int CPR_PD_PROCESSOR_OFF = 1;
  localparam logic [7:0] CPR_EE_RESET = 8'h80;
  localparam logic [7:0] CPR_PD_RESET = 8'h00;
  localparam logic [7:0] CPR_ZERO = 8'h00;
  localparam logic [3:0] CPR_INDEX_MAX = 4'h8;
  // ****************************************
  // RAM access commands
  // ****************************************
  localparam logic [7:0] CPR_CMD_NO_PNP_KEY = 8'h55;
  localparam logic [7:0] CPR_CMD_NO_VEND_KEY = 8'h56;
  localparam logic [7:0] CPR_CMD_JUMP_ROM = 8'h57;
  localparam logic [7:0] CPR_CMD_UPD_HWCFG = 8'h5a;
  localparam logic [7:0] CPR_CMD_DOWNLOAD = 8'haa;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CPR_CLK_MHZ = 50;
  localparam int CPR_CAL_US = 1;
  localparam int CPR_CAL_CYCLES = CPR_CAL_US * CPR_CLK_MHZ;
  typedef enum logic [1:0] {CPR_RAM_CMD, CPR_RAM_ADDR_HI, CPR_RAM_ADDR_LO, CPR_RAM_DATA} cpr_ram_e;
endpackage
`default_nettype wire

//--- rtl/cpr_buf2.sv
// Two-entry valid/ready buffer
`default_nettype none
module cpr_buf2 #(
  parameter int WIDTH = 24
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] cnt;
    logic vld;
  } cpr_buf_s;
  cpr_buf_s st_ff;
  cpr_buf_s nxt_st;
  logic push;
  logic pop;
  initial begin
    if (WIDTH < 1) $error("cpr_buf2: WIDTH must be positive");
  end
  assign in_ready_out = (st_ff.cnt != 2'h2);
  assign out_valid_out = st_ff.vld;
  assign out_data_out = st_ff.mem[0];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.mem[0] = st_ff.mem[1];
    end
    if (push) begin
      if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop)) begin
        nxt_st.mem[0] = in_data_in;
      end else begin
        nxt_st.mem[1] = in_data_in;
      end
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    nxt_st.vld = (nxt_st.cnt != 2'h0);
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

//--- dv/cpr_regs_props.sv
// Checker for the control port register group
`default_nettype none
module cpr_regs_props (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic eeprom_clk_out,
  input wire logic eeprom_dout_out,
  input wire logic eeprom_port_en_out,
  input wire logic peripheral_data_pin0_in,
  input wire logic [1:0] loopback_mux_select_out,
  input wire logic [6:0] section_off_out,
  input wire logic global_power_down_out,
  input wire logic calibrate_out,
  input wire logic [3:0] indirect_index_bits_out,
  input wire logic indirect_wr_out,
  input wire logic pnp_key_off_out,
  input wire logic ram_wr_valid_out,
  input wire logic ram_wr_ready_in,
  input wire logic [7:0] ram_wr_data_out,
  input wire logic ram_busy_out
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  logic up;
  logic ew;
  assign up = !global_power_down_out;
  assign ew = wr_in && addr_in == 3'h1 && up;
  property p_ee_clk; ew |=> eeprom_clk_out == $past(wdata_in[0] & wdata_in[2]); endproperty
  a_ee_clk: assert property (p_ee_clk) else $error("ee clk");
  property p_ee_rd; rd_in && addr_in == 3'h1 && up |=>
    rdata_out[2] == $past(peripheral_data_pin0_in & eeprom_dout_out & eeprom_port_en_out); endproperty
  a_ee_rd: assert property (p_ee_rd) else $error("ee rd");
  property p_mux; ew |=> loopback_mux_select_out == $past(wdata_in[5:4]); endproperty
  a_mux: assert property (p_mux) else $error("mux");
  property p_pd_wr; !up && wr_in && addr_in != 3'h2 |=> $stable(loopback_mux_select_out); endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("pd wr");
  property p_pd_rd; !up && rd_in && addr_in != 3'h2 |=> rdata_out == 8'h00; endproperty
  a_pd_rd: assert property (p_pd_rd) else $error("pd rd");
  property p_cal; $fell(global_power_down_out) |-> ##[0:2] calibrate_out; endproperty
  a_cal: assert property (p_cal) else $error("cal");
  property p_idx; wr_in && addr_in == 3'h4 && up |=> indirect_wr_out == $past(indirect_index_bits_out <= 4'h8);
  endproperty
  a_idx: assert property (p_idx) else $error("idx");
  property p_pnp; wr_in && addr_in == 3'h5 && wdata_in == 8'h55 && up && !ram_busy_out |=> pnp_key_off_out;
  endproperty
  a_pnp: assert property (p_pnp) else $error("pnp");
  property p_hold; ram_wr_valid_out && !ram_wr_ready_in |=> ram_wr_valid_out && $stable(ram_wr_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_blk; wr_in && addr_in == 3'h2 |=> section_off_out[6:2] == $past(wdata_in[6:2]); endproperty
  a_blk: assert property (p_blk) else $error("blk");
  c_take: cover property (ram_wr_valid_out && ram_wr_ready_in);
  c_stall: cover property (ram_wr_valid_out && !ram_wr_ready_in);
  c_wake: cover property ($fell(global_power_down_out));
endmodule
bind cpr_regs cpr_regs_props props_u (.*);
`default_nettype wire

//--- dv/cpr_far_model.sv
// Far side model: RAM write sink and serial eeprom
`default_nettype none
module cpr_far_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  input wire logic ram_wr_valid_in,
  output logic ram_wr_ready_out,
  input wire logic [15:0] ram_wr_addr_in,
  input wire logic [7:0] ram_wr_data_in,
  input wire logic eeprom_clk_in,
  input wire logic eeprom_port_en_in,
  output logic data_pin_out,
  output logic [7:0] took_out,
  output logic [15:0] last_addr_out,
  output logic [7:0] last_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_q;
  always @(posedge sys_clk_in) begin
    clk_q <= eeprom_clk_in;
    if (rst_in) begin
      ram_wr_ready_out <= 1'b0;
      took_out <= 8'h00;
      data_pin_out <= 1'b0;
    end else begin
      ram_wr_ready_out <= !stall_in;
      if (ram_wr_valid_in && ram_wr_ready_out) begin
        took_out <= took_out + 8'h01;
        last_addr_out <= ram_wr_addr_in;
        last_data_out <= ram_wr_data_in;
      end
      if (!eeprom_port_en_in || (eeprom_clk_in && !clk_q)) begin
        data_pin_out <= !data_pin_out;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/test_control_port_registers.sv
// Testbench for the control port register group
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_control_port_registers;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, hwcfg_load_in = 1'b0, stall = 1'b0;
  logic processor_off_if_access_in = 1'b0, modem_irq_pin_in = 1'b0, synth_irq_pin_in = 1'b0, optical_drive_irq_pin_in = 1'b0;
  logic peripheral_data_pin0_in, ram_wr_ready_in, ram_wr_valid_out, ram_busy_out, eeprom_clk_out, eeprom_dout_out;
  logic eeprom_port_en_out, modem_irq_out, synth_irq_out, optical_drive_irq_out, global_power_down_out, calibrate_out;
  logic indirect_wr_out, indirect_rd_out, pnp_key_off_out, vendor_key_off_out, jump_rom_out, hwcfg_update_out;
  logic [2:0] addr_in = 3'h0, hwcfg_pol_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, indirect_rdata_in = 8'h00, rdata_out, indirect_data_bits_out, ram_wr_data_out;
  logic [7:0] took, last_data, got;
  logic [1:0] loopback_mux_select_out;
  logic [6:0] section_off_out;
  logic [3:0] indirect_index_bits_out;
  logic [15:0] ram_wr_addr_out, last_addr;
  logic [7:0] ee_w [4] = '{8'h03, 8'h07, 8'h05, 8'h06};
  int bad_count = 0, samples_checked = 0, cyc = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  cpr_regs #(.RAM_AW(16)) dut_u (.*);
  cpr_far_model far_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .stall_in(stall), .ram_wr_valid_in(ram_wr_valid_out),
    .ram_wr_ready_out(ram_wr_ready_in), .ram_wr_addr_in(ram_wr_addr_out), .ram_wr_data_in(ram_wr_data_out),
    .eeprom_clk_in(eeprom_clk_out), .eeprom_port_en_in(eeprom_port_en_out), .data_pin_out(peripheral_data_pin0_in),
    .took_out(took), .last_addr_out(last_addr), .last_data_out(last_data));
  // ****
  // Access tasks
  // ****
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) #1;
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(posedge sys_clk_in) #1;
    wr_in = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk_in) #1;
    addr_in = a;
    rd_in = 1'b1;
    @(posedge sys_clk_in) #1;
    rd_in = 1'b0;
    got = rdata_out;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out;
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (8) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    rd(3'h1);
    `CHK("ee rst", 8'h80, got)
    rd(3'h2);
    `CHK("pd rst", 8'h00, got)
    $display("test reset done");
    foreach (ee_w[i]) begin
      wr(3'h1, ee_w[i]);
      `CHK("ee pins", ee_w[i][2] ? ee_w[i][2:0] : 3'h0, {eeprom_port_en_out, eeprom_dout_out, eeprom_clk_out})
      rd(3'h1);
      `CHK("ee din", ee_w[i][2] & ee_w[i][1] & peripheral_data_pin0_in, got[2])
    end
    $display("test eeprom done");
    {optical_drive_irq_pin_in, synth_irq_pin_in, modem_irq_pin_in} = 3'b101;
    for (int m = 0; m < 4; m++) begin
      wr(3'h1, {m[1:0], m[1:0], ~m[0], 3'h0});
      `CHK("mux", m[1:0], loopback_mux_select_out)
      @(posedge sys_clk_in) #1;
      `CHK("irq", ~({m[1:0], ~m[0]} ^ 3'b101), {optical_drive_irq_out, synth_irq_out, modem_irq_out})
    end
    hwcfg_pol_in = 3'b010;
    hwcfg_load_in = 1'b1;
    @(posedge sys_clk_in) #1;
    hwcfg_load_in = 1'b0;
    @(posedge sys_clk_in) #1;
    `CHK("hw pol", 3'b000, {optical_drive_irq_out, synth_irq_out, modem_irq_out})
    $display("test polarity done");
    wr(3'h3, 8'h08);
    `CHK("idx", 4'h8, indirect_index_bits_out)
    wr(3'h4, 8'h3c);
    `CHK("iwr", 2'b11, {indirect_wr_out, indirect_data_bits_out == 8'h3c})
    indirect_rdata_in = 8'ha5;
    rd(3'h4);
    `CHK("ird", 8'ha5, got)
    `CHK("ird pulse", 1'b1, indirect_rd_out)
    wr(3'h3, 8'h09);
    wr(3'h4, 8'h11);
    `CHK("iwr off", 1'b0, indirect_wr_out)
    wr(3'h5, 8'h55);
    `CHK("pnp", 1'b1, pnp_key_off_out)
    wr(3'h5, 8'h56);
    `CHK("vend", 1'b1, vendor_key_off_out)
    wr(3'h5, 8'h57);
    `CHK("rom", 1'b1, jump_rom_out)
    wr(3'h5, 8'h5a);
    `CHK("hwu", 1'b1, hwcfg_update_out)
    $display("test commands done");
    stall = 1'b1;
    wr(3'h5, 8'haa);
    `CHK("busy", 1'b1, ram_busy_out)
    wr(3'h5, 8'h01);
    wr(3'h5, 8'h00);
    for (int k = 0; k < 4; k++) wr(3'h5, 8'h3c + 8'(k));
    `CHK("held", 2'b11, {ram_wr_valid_out, ram_wr_data_out == 8'h3c})
    stall = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1 `CHK("taken", {8'h02, 16'h0101, 8'h3d}, {took, last_addr, last_data})
    `CHK("drained", 1'b0, ram_wr_valid_out)
    wr(3'h6, 8'h00);
    `CHK("cmd mode", 1'b0, ram_busy_out)
    $display("test download done");
    wr(3'h2, 8'h80);
    wr(3'h1, 8'h17);
    rd(3'h1);
    `CHK("pd rd", 2'b10, {got == 8'h00, loopback_mux_select_out == 2'h1})
    rd(3'h2);
    `CHK("pd self", 8'h80, got)
    `CHK("gpd", 1'b1, global_power_down_out)
    wr(3'h2, 8'h00);
    `CHK("cal", 1'b1, calibrate_out)
    repeat (45) @(posedge sys_clk_in);
    #1 `CHK("cal hold", 1'b1, calibrate_out)
    repeat (10) @(posedge sys_clk_in);
    #1 `CHK("cal end", 2'b01, {calibrate_out, section_off_out[1]})
    processor_off_if_access_in = 1'b1;
    @(posedge sys_clk_in) #1;
    processor_off_if_access_in = 1'b0;
    @(posedge sys_clk_in) #1;
    `CHK("wake", 1'b0, section_off_out[1])
    wr(3'h2, 8'h7d);
    `CHK("blk", 7'h7d, section_off_out)
    wr(3'h2, 8'h80);
    wr(3'h2, 8'h00);
    `CHK("asleep", 1'b1, section_off_out[1])
    wr(3'h2, 8'h00);
    `CHK("wake twice", 1'b0, section_off_out[1])
    $display("test power done");
    close_out;
  end
endmodule
`default_nettype wire
